// ==== fifo_clear_ctrl_cfg.svh ====
`ifndef FIFO_CLEAR_CTRL_CFG_SVH
`define FIFO_CLEAR_CTRL_CFG_SVH
`define CLEAR_LEN_CYCLES 8
`define ADDR_REG_WIDTH 10
`define ADDR_REG_RESET 10'h000
`define MASK_8BIT 10'h0ff
`define MASK_10BIT 10'h3ff
`endif

// ==== fifo_clear_pkg.sv ====
package fifo_clear_pkg;
  // One-hot sequencer states
  typedef enum logic [2:0]
  {
    SEQ_IDLE = 3'b001,
    SEQ_COUNT = 3'b010,
    SEQ_HOLD = 3'b100
  } seq_state_e;
  // Transmit flag group, active low
  typedef struct packed
  {
    logic empty_n;
    logic half_n;
    logic full_n;
  } tx_flags_s;
endpackage : fifo_clear_pkg

// ==== clear_seq.sv ====
`timescale 1ns/1ps
`default_nettype none
module clear_seq #(
  parameter int LEN = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req,
  input wire logic inhibit,
  output logic hold,
  output logic release_pulse,
  output logic [$clog2(LEN+1)-1:0] cnt
);
  localparam int CW = $clog2(LEN+1);
  fifo_clear_pkg::seq_state_e state_q;
  if (LEN < 2)
  begin : g_len_chk
    $error("clear_seq: LEN must be at least 2");
  end
  // Sequence state and saturating cycle count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= fifo_clear_pkg::SEQ_IDLE;
      cnt <= '0;
    end
    else
    begin
      case (state_q)
        fifo_clear_pkg::SEQ_IDLE:
        begin
          if (req && !inhibit)
          begin
            state_q <= fifo_clear_pkg::SEQ_COUNT;
            cnt <= CW'(1);
          end
        end
        fifo_clear_pkg::SEQ_COUNT:
        begin
          // Enable or broken condition restarts from zero
          if (!req || inhibit)
          begin
            state_q <= fifo_clear_pkg::SEQ_IDLE;
            cnt <= '0;
          end
          else if (cnt == CW'(LEN - 1))
          begin
            state_q <= fifo_clear_pkg::SEQ_HOLD;
            cnt <= CW'(LEN);
          end
          else
            cnt <= cnt + CW'(1);
        end
        fifo_clear_pkg::SEQ_HOLD:
        begin
          // Saturated; waits for the host to drop a request
          if (!req)
          begin
            state_q <= fifo_clear_pkg::SEQ_IDLE;
            cnt <= '0;
          end
        end
        default:
        begin
          state_q <= fifo_clear_pkg::SEQ_IDLE;
          cnt <= '0;
        end
      endcase
    end
  end
  // Release pulse one cycle after condition drops
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      release_pulse <= 1'b0;
    else
      release_pulse <= (state_q == fifo_clear_pkg::SEQ_HOLD) && !req;
  end
  assign hold = (state_q == fifo_clear_pkg::SEQ_HOLD);
endmodule : clear_seq
`default_nettype wire

// ==== addr_match_reg.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fifo_clear_ctrl_cfg.svh"
module addr_match_reg #(
  parameter int W = `ADDR_REG_WIDTH
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr,
  input wire logic [W-1:0] wdata,
  input wire logic wunicast,
  input wire logic width8,
  input wire logic char_valid,
  input wire logic [W-1:0] char_in,
  output logic [W-1:0] value,
  output logic unicast,
  output logic match
);
  logic [W-1:0] mask;
  logic [W-1:0] same;
  if (W != 10)
  begin : g_w_chk
    $error("addr_match_reg: W must be 10");
  end
  // Only the low eight lines count in byte mode
  assign mask = width8 ? `MASK_8BIT : `MASK_10BIT;
  assign same = ~(value ^ char_in) & mask;
  // Register contents and match mode
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      value <= `ADDR_REG_RESET;
      unicast <= 1'b0;
    end
    else if (wr)
    begin
      value <= wdata & mask;
      unicast <= wunicast;
    end
  end
  // Match result registered per incoming character
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      match <= 1'b0;
    else if (char_valid)
      match <= unicast ? (same == mask) : (|same);
  end
endmodule : addr_match_reg
`default_nettype wire

// ==== fifo_clear_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fifo_clear_ctrl_cfg.svh"
module fifo_clear_ctrl #(
  parameter int CLEAR_LEN = `CLEAR_LEN_CYCLES
) (
  input wire logic CORE_CLK_IN,
  input wire logic RESETN_IN,
  input wire logic ADDR_SELECT_N_IN,
  input wire logic TX_FIFO_CLEAR_REQ_N_IN,
  input wire logic RX_FIFO_CLEAR_REQ_N_IN,
  input wire logic TRANSMIT_ENABLE_N_IN,
  input wire logic RECEIVE_ENABLE_N_IN,
  input wire logic EXTERNAL_QUEUE_TIMING_SEL_IN,
  input wire logic CHAR_WIDTH_SEL_IN,
  input wire logic SPECIAL_DATA_SEL_IN,
  input wire logic REG_READ_WRITE_SEL_IN,
  input wire logic [9:0] RECEIVE_DATA_BUS_IN,
  input wire logic TX_LEVEL_EMPTY_IN,
  input wire logic TX_LEVEL_HALF_IN,
  input wire logic TX_LEVEL_FULL_IN,
  input wire logic RX_LEVEL_EMPTY_IN,
  input wire logic RX_FIFO_WRITE_IN,
  input wire logic ADDR_CHAR_VALID_IN,
  input wire logic [9:0] ADDR_CHAR_IN,
  output logic [9:0] RECEIVE_DATA_BUS_OUT,
  output logic RECEIVE_DATA_BUS_OE_OUT,
  output logic TRANSMIT_EMPTY_FLAG_N_OUT,
  output logic TRANSMIT_HALF_FLAG_N_OUT,
  output logic TRANSMIT_FULL_FLAG_N_OUT,
  output logic TX_FLAG_OE_OUT,
  output logic RX_EMPTY_FLAG_N_OUT,
  output logic RX_FLAG_OE_OUT,
  output logic TX_WRITE_BLOCK_OUT,
  output logic TX_FIFO_CLEAR_OUT,
  output logic RX_FIFO_CLEAR_OUT,
  output logic RX_SELECTED_OUT,
  output logic ADDR_MATCH_OUT
);
  localparam int CW = $clog2(CLEAR_LEN + 1);
  if (CLEAR_LEN != 8)
  begin : g_len_chk
    $error("fifo_clear_ctrl: CLEAR_LEN must be 8");
  end

  // Sampled request conditions
  logic tx_req;
  logic rx_req;
  logic tx_inh;
  logic rx_inh;
  logic tx_hold;
  logic rx_hold;
  logic tx_rel;
  logic rx_rel;
  logic [CW-1:0] tx_cnt;
  logic [CW-1:0] rx_cnt;
  fifo_clear_pkg::tx_flags_s tx_flags_q;
  logic rx_match_q;
  logic receive_enable_n_n_q;
  logic rx_block_q;
  logic rx_lock_q;
  logic rx_empty_force_q;
  logic reg_space;
  logic reg_strobe;
  logic reg_wr;
  logic [9:0] reg_value;
  logic reg_unicast;

  // Reset-match conditions on the current edge
  assign tx_req = !ADDR_SELECT_N_IN && !TX_FIFO_CLEAR_REQ_N_IN;
  assign rx_req = !ADDR_SELECT_N_IN && !RX_FIFO_CLEAR_REQ_N_IN;

  // Enable polarity flips with the timing mode
  assign tx_inh = EXTERNAL_QUEUE_TIMING_SEL_IN ?
                  !TRANSMIT_ENABLE_N_IN : TRANSMIT_ENABLE_N_IN;
  assign rx_inh = EXTERNAL_QUEUE_TIMING_SEL_IN ?
                  !RECEIVE_ENABLE_N_IN : RECEIVE_ENABLE_N_IN;

  // Transmit clear sequencer
  clear_seq #(
    .LEN(CLEAR_LEN)
  ) u_tx_seq (
    .clk(CORE_CLK_IN),
    .rst_n(RESETN_IN),
    .req(tx_req),
    .inhibit(tx_inh),
    .hold(tx_hold),
    .release_pulse(tx_rel),
    .cnt(tx_cnt)
  );

  // Receive clear sequencer, same counting as transmit
  clear_seq #(
    .LEN(CLEAR_LEN)
  ) u_rx_seq (
    .clk(CORE_CLK_IN),
    .rst_n(RESETN_IN),
    .req(rx_req),
    .inhibit(rx_inh),
    .hold(rx_hold),
    .release_pulse(rx_rel),
    .cnt(rx_cnt)
  );

  // Internal clears fire only once the host lets go
  assign TX_FIFO_CLEAR_OUT = tx_rel;
  assign RX_FIFO_CLEAR_OUT = rx_rel;
  // A forced full is hard, unlike the normal full slack
  assign TX_WRITE_BLOCK_OUT = tx_hold;

  // Transmit flags: forced full during operation, else live levels
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      tx_flags_q <= '{empty_n: 1'b0, half_n: 1'b1, full_n: 1'b1};
    else if (tx_hold)
      tx_flags_q <= '{empty_n: 1'b1, half_n: 1'b0, full_n: 1'b0};
    else
      tx_flags_q <= '{empty_n: !TX_LEVEL_EMPTY_IN,
                      half_n: !TX_LEVEL_HALF_IN,
                      full_n: !TX_LEVEL_FULL_IN};
  end
  assign TRANSMIT_EMPTY_FLAG_N_OUT = tx_flags_q.empty_n;
  assign TRANSMIT_HALF_FLAG_N_OUT = tx_flags_q.half_n;
  assign TRANSMIT_FULL_FLAG_N_OUT = tx_flags_q.full_n;

  // Flag drivers follow address select; a clear release by the request line keeps them on
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      TX_FLAG_OE_OUT <= 1'b0;
      RX_FLAG_OE_OUT <= 1'b0;
    end
    else
    begin
      TX_FLAG_OE_OUT <= !ADDR_SELECT_N_IN;
      RX_FLAG_OE_OUT <= !ADDR_SELECT_N_IN;
    end
  end

  // Receive empty is forced until fresh data lands
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      rx_empty_force_q <= 1'b0;
    else if (rx_hold)
      rx_empty_force_q <= 1'b1;
    else if (RX_FIFO_WRITE_IN)
      rx_empty_force_q <= 1'b0;
  end
  assign RX_EMPTY_FLAG_N_OUT = !(rx_empty_force_q || RX_LEVEL_EMPTY_IN);

  // Receive normal match and previous enable level
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rx_match_q <= 1'b0;
      receive_enable_n_n_q <= 1'b1;
    end
    else
    begin
      rx_match_q <= !ADDR_SELECT_N_IN && RX_FIFO_CLEAR_REQ_N_IN;
      receive_enable_n_n_q <= RECEIVE_ENABLE_N_IN;
    end
  end

  // Blind cycle after release, and lockout if enable hit it
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      rx_block_q <= 1'b0;
      rx_lock_q <= 1'b0;
    end
    else
    begin
      rx_block_q <= rx_rel;
      if (RECEIVE_ENABLE_N_IN)
        rx_lock_q <= 1'b0;
      else if (rx_rel)
        rx_lock_q <= 1'b1;
    end
  end

  // Selection needs a fresh high-to-low enable edge under match
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
      RX_SELECTED_OUT <= 1'b0;
    else if (RECEIVE_ENABLE_N_IN || rx_lock_q || rx_rel)
      RX_SELECTED_OUT <= 1'b0;
    else if (receive_enable_n_n_q && rx_match_q && !rx_block_q)
      RX_SELECTED_OUT <= 1'b1;
  end

  // Register space only with a receive reset-match in UTOPIA timing
  assign reg_space = rx_req && !EXTERNAL_QUEUE_TIMING_SEL_IN;
  // Held enable never makes a strobe, so no write under it
  assign reg_strobe = reg_space && receive_enable_n_n_q
                      && !RECEIVE_ENABLE_N_IN;
  assign reg_wr = reg_strobe && !REG_READ_WRITE_SEL_IN;

  addr_match_reg #(
    .W(`ADDR_REG_WIDTH)
  ) u_addr_reg (
    .clk(CORE_CLK_IN),
    .rst_n(RESETN_IN),
    .wr(reg_wr),
    .wdata(RECEIVE_DATA_BUS_IN),
    .wunicast(SPECIAL_DATA_SEL_IN),
    .width8(CHAR_WIDTH_SEL_IN),
    .char_valid(ADDR_CHAR_VALID_IN),
    .char_in(ADDR_CHAR_IN),
    .value(reg_value),
    .unicast(reg_unicast),
    .match(ADDR_MATCH_OUT)
  );

  // Read data driven while strobe held with read selected
  always_ff @(posedge CORE_CLK_IN or negedge RESETN_IN)
  begin
    if (!RESETN_IN)
    begin
      RECEIVE_DATA_BUS_OUT <= 10'h000;
      RECEIVE_DATA_BUS_OE_OUT <= 1'b0;
    end
    else
    begin
      RECEIVE_DATA_BUS_OE_OUT <= reg_space && !RECEIVE_ENABLE_N_IN
                                 && REG_READ_WRITE_SEL_IN;
      RECEIVE_DATA_BUS_OUT <= reg_value;
    end
  end

  // Checks
  default clocking cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  sequence tx_run_s;
    (tx_req && !tx_inh) [*8];
  endsequence
  sequence rx_run_s;
    (rx_req && !rx_inh) [*8];
  endsequence
  sequence tx_rel_s;
    tx_hold && !tx_req;
  endsequence

  tx_start_a: assert property (
    !tx_hold && tx_cnt == '0 && tx_req && !tx_inh |=> tx_cnt == CW'(1))
    else $error("transmit sequence did not start");
  tx_count_a: assert property (
    tx_run_s |=> tx_hold)
    else $error("transmit operation late after eight cycles");
  tx_early_a: assert property (
    $rose(tx_hold) |-> $past(tx_cnt) == CW'(7))
    else $error("transmit operation started early");
  tx_inhibit_a: assert property (
    !tx_hold && tx_inh |=> tx_cnt == '0)
    else $error("transmit enable did not hold off");
  tx_full_a: assert property (
    tx_hold |=> !TRANSMIT_FULL_FLAG_N_OUT && !TRANSMIT_HALF_FLAG_N_OUT
      && TRANSMIT_EMPTY_FLAG_N_OUT)
    else $error("transmit flags not forced full");
  tx_block_a: assert property (
    $past(tx_hold) && tx_hold
      |-> TX_WRITE_BLOCK_OUT && !TRANSMIT_FULL_FLAG_N_OUT)
    else $error("writes not blocked in forced full");
  tx_release_a: assert property (
    tx_rel_s |=> TX_FIFO_CLEAR_OUT ##1 !TX_FIFO_CLEAR_OUT)
    else $error("transmit clear not one pulse on release");
  tx_noclear_a: assert property (
    TX_FIFO_CLEAR_OUT |-> $past(tx_hold) && !$past(tx_req))
    else $error("transmit clear without release");
  tx_flag_off_a: assert property (
    tx_hold && ADDR_SELECT_N_IN |=> !TX_FLAG_OE_OUT)
    else $error("transmit flags still driven");
  tx_flag_keep_a: assert property (
    tx_hold && !ADDR_SELECT_N_IN && TX_FIFO_CLEAR_REQ_N_IN
      |=> TX_FLAG_OE_OUT ##1 (TX_FLAG_OE_OUT || $past(ADDR_SELECT_N_IN)))
    else $error("transmit flags dropped on match change");
  tx_done_a: assert property (
    !tx_hold && TX_LEVEL_EMPTY_IN && !TX_LEVEL_HALF_IN && !TX_LEVEL_FULL_IN
      |=> !TRANSMIT_EMPTY_FLAG_N_OUT && TRANSMIT_FULL_FLAG_N_OUT
      && TRANSMIT_HALF_FLAG_N_OUT)
    else $error("transmit completion not shown as empty");
  rx_count_a: assert property (
    rx_run_s |=> rx_hold)
    else $error("receive operation late after eight cycles");
  rx_empty_a: assert property (
    rx_hold |=> !RX_EMPTY_FLAG_N_OUT)
    else $error("receive flags not forced empty");
  rx_usable_a: assert property (
    rx_empty_force_q && !rx_hold && RX_FIFO_WRITE_IN |=> !rx_empty_force_q)
    else $error("receive empty not lifted by new data");
  rx_release_a: assert property (
    rx_hold && !rx_req |=> RX_FIFO_CLEAR_OUT)
    else $error("receive clear missing on release");
  rx_blind_a: assert property (
    RX_FIFO_CLEAR_OUT && !RECEIVE_ENABLE_N_IN
      ##1 (!RECEIVE_ENABLE_N_IN)[*2] |=> !RX_SELECTED_OUT)
    else $error("receive selected in blind cycle");
  reg_mode_a: assert property (
    EXTERNAL_QUEUE_TIMING_SEL_IN |=> $stable(reg_value))
    else $error("register written outside UTOPIA timing");
  reg_write_a: assert property (
    reg_strobe && !REG_READ_WRITE_SEL_IN && !CHAR_WIDTH_SEL_IN
      |=> reg_value == $past(RECEIVE_DATA_BUS_IN))
    else $error("register write lost");
  reg_byte_a: assert property (
    reg_wr && CHAR_WIDTH_SEL_IN |=> reg_value[9:8] == 2'h0)
    else $error("byte mode wrote upper lines");
  reg_uni_a: assert property (
    reg_wr |=> reg_unicast == $past(SPECIAL_DATA_SEL_IN))
    else $error("match mode not taken from data select");
  // Counted from an idle start, so a long hold cannot look short
  rx_short_a: assert property (
    rx_cnt == '0 && rx_req && !rx_inh ##1 (rx_req && !rx_inh)[*6]
      ##1 !rx_req |=> !rx_hold && !RX_FIFO_CLEAR_OUT)
    else $error("short request cleared receive queue");
  rx_cont_a: assert property (
    !RECEIVE_ENABLE_N_IN && !$past(RECEIVE_ENABLE_N_IN) |-> !reg_wr)
    else $error("write under continuous selection");
  tx_abort_a: assert property (
    !tx_hold && !tx_req |=> tx_cnt == '0)
    else $error("transmit sequence not aborted");
  rx_sat_a: assert property (
    rx_hold && rx_req |=> rx_hold && rx_cnt == CW'(CLEAR_LEN))
    else $error("receive counter not saturated");
  tx_sat_a: assert property (
    tx_hold && tx_req |=> tx_hold && tx_cnt == CW'(CLEAR_LEN))
    else $error("transmit counter not saturated");
  rx_abort_a: assert property (
    !rx_hold && !rx_req |=> rx_cnt == '0)
    else $error("receive sequence not aborted");
  rx_noclear_a: assert property (
    RX_FIFO_CLEAR_OUT |-> $past(rx_hold) && !$past(rx_req))
    else $error("receive clear without release");
  rx_select_a: assert property (
    RECEIVE_ENABLE_N_IN |=> !RX_SELECTED_OUT)
    else $error("receive selected without enable");
endmodule : fifo_clear_ctrl
`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic [9:0] dev_data_in,
  input wire logic dev_oe_in,
  output logic sel_n_out,
  output logic txr_n_out,
  output logic rxr_n_out,
  output logic txe_n_out,
  output logic rxe_n_out,
  output logic cascade_out,
  output logic width8_out,
  output logic unicast_out,
  output logic rd_out,
  output logic [9:0] bus_out
);
  logic [9:0] wdata;
  logic wdrive;
  // Shared bus: stale data is inverted so a missed read never matches
  assign bus_out = dev_oe_in ? dev_data_in : (wdrive ? wdata : ~wdata);
  // Idle host: deselected, no requests, UTOPIA timing, 10-bit width
  initial
  begin
    {sel_n_out, txr_n_out, rxr_n_out, txe_n_out, rxe_n_out} = 5'h1c;
    cascade_out = 1'b0;
    width8_out = 1'b0;
    unicast_out = 1'b0;
    rd_out = 1'b0;
    wdata = 10'h000;
    wdrive = 1'b0;
  end
  // Pins change only at the falling edge
  task step(input int n);
    repeat (n) @(negedge clk_in);
  endtask : step
  // Order is select, tx clear, rx clear, tx enable, rx enable
  task drive(input logic [4:0] v);
    {sel_n_out, txr_n_out, rxr_n_out, txe_n_out, rxe_n_out} = v;
  endtask : drive
  // Timing mode and character width, changed only between accesses
  task set_mode(input logic w8, input logic casc);
    width8_out = w8;
    cascade_out = casc;
  endtask : set_mode
  // Strobe held through one edge, then released for a full cycle
  task reg_write(input logic [9:0] d, input logic uni);
    wdata = d;
    wdrive = 1'b1;
    unicast_out = uni;
    rd_out = 1'b0;
    rxe_n_out = 1'b0;
    step(1);
    rxe_n_out = 1'b1;
    wdrive = 1'b0;
    step(1);
  endtask : reg_write
  // Read data is registered; it is sampled two edges after the strobe falls
  task reg_read(output logic [9:0] q, output logic oe);
    rd_out = 1'b1;
    rxe_n_out = 1'b0;
    step(2);
    q = bus_out;
    oe = dev_oe_in;
    rxe_n_out = 1'b1;
    step(1);
  endtask : reg_read
endmodule : host_model
`default_nettype wire

// ==== tb_fifo_clear_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_fifo_clear_ctrl;
  logic clk, rst_n, sel_n, txr_n, rxr_n, txe_n, rxe_n, casc, w8, uni, rd;
  logic [9:0] bus, dout, ach, q;
  logic [2:0] tx_lvl, txf;
  logic rx_lvl, rx_wr, ach_v, doe, tx_oe, rx_e_n, rx_oe, wblk, oe;
  logic tx_clr, rx_clr, rx_sel, match;
  int errors, n_tests, cycles, tx_pulses, rx_pulses;
  host_model hm (.clk_in(clk), .dev_data_in(dout), .dev_oe_in(doe),
    .sel_n_out(sel_n), .txr_n_out(txr_n), .rxr_n_out(rxr_n),
    .txe_n_out(txe_n), .rxe_n_out(rxe_n), .cascade_out(casc),
    .width8_out(w8), .unicast_out(uni), .rd_out(rd), .bus_out(bus));
  fifo_clear_ctrl #(.CLEAR_LEN(8)) DUT (.CORE_CLK_IN(clk),
    .RESETN_IN(rst_n), .ADDR_SELECT_N_IN(sel_n),
    .TX_FIFO_CLEAR_REQ_N_IN(txr_n), .RX_FIFO_CLEAR_REQ_N_IN(rxr_n),
    .TRANSMIT_ENABLE_N_IN(txe_n), .RECEIVE_ENABLE_N_IN(rxe_n),
    .EXTERNAL_QUEUE_TIMING_SEL_IN(casc), .CHAR_WIDTH_SEL_IN(w8),
    .SPECIAL_DATA_SEL_IN(uni), .REG_READ_WRITE_SEL_IN(rd),
    .RECEIVE_DATA_BUS_IN(bus), .TX_LEVEL_EMPTY_IN(tx_lvl[2]),
    .TX_LEVEL_HALF_IN(tx_lvl[1]), .TX_LEVEL_FULL_IN(tx_lvl[0]),
    .RX_LEVEL_EMPTY_IN(rx_lvl), .RX_FIFO_WRITE_IN(rx_wr),
    .ADDR_CHAR_VALID_IN(ach_v), .ADDR_CHAR_IN(ach),
    .RECEIVE_DATA_BUS_OUT(dout), .RECEIVE_DATA_BUS_OE_OUT(doe),
    .TRANSMIT_EMPTY_FLAG_N_OUT(txf[2]), .TRANSMIT_HALF_FLAG_N_OUT(txf[1]),
    .TRANSMIT_FULL_FLAG_N_OUT(txf[0]), .TX_FLAG_OE_OUT(tx_oe),
    .RX_EMPTY_FLAG_N_OUT(rx_e_n), .RX_FLAG_OE_OUT(rx_oe),
    .TX_WRITE_BLOCK_OUT(wblk), .TX_FIFO_CLEAR_OUT(tx_clr),
    .RX_FIFO_CLEAR_OUT(rx_clr), .RX_SELECTED_OUT(rx_sel),
    .ADDR_MATCH_OUT(match));
  // Free-running core clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Hang guard, well above the roughly 140 cycles the tests need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      report_and_stop();
    end
  end
  // Pulses counted at the settled edge to catch repeats and strays
  always @(negedge clk)
  begin
    if (tx_clr === 1'b1) tx_pulses++;
    if (rx_clr === 1'b1) rx_pulses++;
  end
  task check_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_bit
  task check_word(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_word
  // Incoming address character, match registered on the valid edge
  task addr_char(input logic [9:0] c);
    ach = c;
    ach_v = 1'b1;
    hm.step(1);
    ach_v = 1'b0;
  endtask : addr_char
  task report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    {errors, n_tests, cycles, tx_pulses, rx_pulses} = '0;
    {rst_n, rx_lvl, rx_wr, ach_v, ach, tx_lvl} = {1'b0, 13'h0000, 3'h4};
    repeat (3) @(posedge clk);
    @(negedge clk);
    check_word({7'h00, txf}, 10'h003);
    check_bit(tx_oe, 1'b0);
    rst_n = 1'b1;
    // Transmit clear released by the request line
    hm.drive(5'h04);
    hm.step(8);
    check_bit(txf[0], 1'b1);
    hm.step(1);
    check_word({7'h00, txf}, 10'h004);
    check_bit(wblk, 1'b1);
    hm.step(10);
    check_word({7'h00, txf}, 10'h004);
    hm.drive(5'h0c);
    hm.step(1);
    check_bit(tx_oe, 1'b1);
    check_bit(tx_clr, 1'b1);
    hm.step(1);
    check_bit(tx_clr, 1'b0);
    check_word({7'h00, txf}, 10'h003);
    $display("test tx clear by request done");
    // Transmit clear released by address select, then re-addressed
    hm.drive(5'h04);
    hm.step(10);
    check_word({7'h00, txf}, 10'h004);
    hm.drive(5'h14);
    hm.step(1);
    check_bit(tx_oe, 1'b0);
    hm.step(2);
    hm.drive(5'h0c);
    hm.step(1);
    check_bit(tx_oe, 1'b1);
    check_word({7'h00, txf}, 10'h003);
    $display("test tx clear by select done");
    // Active enable holds the sequence off until removed
    hm.drive(5'h06);
    hm.step(14);
    check_bit(wblk, 1'b0);
    hm.drive(5'h04);
    hm.step(10);
    check_bit(wblk, 1'b1);
    hm.drive(5'h0c);
    hm.step(3);
    $display("test tx enable inhibit done");
    // Seven-cycle sequences broken by select, then by request
    hm.drive(5'h04);
    hm.step(7);
    hm.drive(5'h14);
    hm.step(1);
    hm.drive(5'h04);
    hm.step(7);
    hm.drive(5'h0c);
    tx_lvl = 3'h1;
    hm.step(4);
    check_word({7'h00, txf}, 10'h006);
    check_bit(wblk, 1'b0);
    tx_lvl = 3'h2;
    hm.step(1);
    check_word({7'h00, txf}, 10'h005);
    tx_lvl = 3'h4;
    check_word(10'(tx_pulses), 10'h003);
    $display("test tx abort done");
    // Receive clear, blind cycle after release, then new data
    hm.drive(5'h08);
    hm.step(10);
    check_bit(rx_e_n, 1'b0);
    check_bit(rx_oe, 1'b1);
    hm.drive(5'h09);
    hm.step(1);
    hm.drive(5'h0d);
    hm.step(1);
    check_bit(rx_clr, 1'b1);
    hm.drive(5'h0c);
    hm.step(4);
    check_bit(rx_sel, 1'b0);
    check_bit(rx_e_n, 1'b0);
    hm.drive(5'h0d);
    hm.step(1);
    hm.drive(5'h0c);
    hm.step(2);
    check_bit(rx_sel, 1'b1);
    rx_wr = 1'b1;
    hm.step(1);
    rx_wr = 1'b0;
    hm.step(1);
    check_bit(rx_e_n, 1'b1);
    rx_lvl = 1'b1;
    hm.step(1);
    check_bit(rx_e_n, 1'b0);
    rx_lvl = 1'b0;
    hm.drive(5'h0d);
    hm.step(1);
    $display("test rx clear done");
    // Address register access through the receive data bus
    hm.drive(5'h09);
    hm.step(1);
    hm.reg_write(10'h2a5, 1'b1);
    hm.reg_read(q, oe);
    check_bit(oe, 1'b1);
    check_word(q, 10'h2a5);
    addr_char(10'h2a5);
    check_bit(match, 1'b1);
    addr_char(10'h2a4);
    check_bit(match, 1'b0);
    hm.reg_write(10'h001, 1'b0);
    addr_char(10'h3ff);
    check_bit(match, 1'b1);
    addr_char(10'h3fe);
    check_bit(match, 1'b0);
    hm.set_mode(1'b1, 1'b0);
    hm.reg_write(10'h3a5, 1'b1);
    hm.reg_read(q, oe);
    check_word(q, 10'h0a5);
    hm.set_mode(1'b0, 1'b1);
    hm.reg_write(10'h155, 1'b1);
    hm.set_mode(1'b0, 1'b0);
    hm.reg_read(q, oe);
    check_word(q, 10'h0a5);
    hm.drive(5'h08);
    hm.step(7);
    hm.drive(5'h0d);
    hm.step(3);
    check_bit(rx_e_n, 1'b1);
    check_word(10'(rx_pulses), 10'h001);
    $display("test address register done");
    report_and_stop();
  end
endmodule : tb_fifo_clear_ctrl
`default_nettype wire
